// [core/clb_pkg.sv]
// Constants and types shared by the logic block model
package clb_pkg;
    // Array and macrocell dimensions
    localparam int NUM_IN = 36;
    localparam int LIT_W = 72;
    localparam int NUM_TERMS = 87;
    localparam int GEN_TERMS = 80;
    localparam int NUM_MC = 16;
    localparam int HALF_MC = 8;
    localparam int GRP_MC = 4;
    localparam int GRP_TERMS = 20;
    localparam int MAX_SUM = 16;
    localparam int NUM_GCLK = 4;
    localparam int NUM_DED = 5;
    localparam int NUM_CTL = 7;
    // Positions of the control terms in the array
    localparam int OE_BASE = 80;
    localparam int SET_TERM = 84;
    localparam int RST_TERM = 85;
    localparam int PTCLK_TERM = 86;
    // Control inversion bit positions, relative to OE_BASE
    localparam int INV_SET = 4;
    localparam int INV_RST = 5;
    localparam int INV_PTCLK = 6;
    // Clock select codes; codes above the product-term clock select nothing
    localparam logic [2:0] CLK_SEL_PT = 3'h4;
    // Reset values
    localparam logic [15:0] MC_RESET = 16'h0000;
    localparam logic [3:0] GCLK_RESET = 4'h0;
    // Storage element modes
    typedef enum logic [1:0] {
        CLB_MODE_COMB,
        CLB_MODE_DREG,
        CLB_MODE_TREG,
        CLB_MODE_LATCH
    } clb_mode_e;
endpackage

// [core/clb_logic_block.sv]
// One programmable logic block: routing, product term array, allocator and 16 macrocells
//
// Notes on behaviour
// - Routing matrix takes all pins, dedicated inputs and feedbacks; selected ones reach the block.
// - Block receives 36 routed signals and forms true and inverted copies, 72 literals.
// - Array has 87 AND terms, each using any mix of the 72 literals.
// - Eighty general terms feed the macrocells; seven terms serve enable, set, reset, clock.
// - Four enable terms; upper half picks first two, lower half picks last two.
// - One asynchronous set and one reset term, shared by all macrocell registers.
// - Set, reset, enable and term clock each have selectable inversion.
// - Block holds a high speed or low power mode setting.
// - Any macrocell may sum zero to sixteen general terms.
// - One term may feed several macrocells within a group of four.
// - Sixteen macrocells, each either pin-connected or buried.
// - Storage is combinational, D register, T register or transparent latch.
// - Register clock is one of four global clocks or the term clock.
// - Clock edge polarity is set once for the whole block.
// - Buried macrocell can capture the neighbouring pin as D register or latch.
// - Every buried macrocell result always returns to the routing matrix.
// - Pin-connected macrocell has an output inversion stage.
// - Feedback path is separate from the pin input path.
// - Undriven pin weakly holds the last level seen on it.
`timescale 1ns/1ps

module clb_logic_block #(
    parameter int EXT_W = 16,                          // Sources from other blocks
    parameter logic [15:0] IO_MASK = 16'h5555,         // Macrocells that own a pin
    parameter int SRC_W = 2 * clb_pkg::NUM_MC + clb_pkg::NUM_DED + EXT_W,
    parameter int SEL_W = $clog2(SRC_W)
) (
    input wire logic clk,                                                   // Block clock, 250 MHz
    input wire logic reset,                                                 // Async reset, active high
    input wire logic [clb_pkg::NUM_MC-1:0] pin_in,                          // Pin levels, asynchronous
    output logic [clb_pkg::NUM_MC-1:0] pin_out,                             // Level driven to each pin
    output logic [clb_pkg::NUM_MC-1:0] pin_oe,                              // High while a pin is driven
    output logic [clb_pkg::NUM_MC-1:0] pin_hold,                            // Weak hold level per pin
    input wire logic [clb_pkg::NUM_DED-1:0] ded_in,                         // Dedicated input pins
    input wire logic [clb_pkg::NUM_GCLK-1:0] gclk_in,                       // Global clock pins
    input wire logic [EXT_W-1:0] ext_src,                                   // Feedbacks of other blocks
    output logic [clb_pkg::NUM_MC-1:0] fb_out,                              // Feedback to the routing matrix
    input wire logic [clb_pkg::NUM_IN-1:0][SEL_W-1:0] cfg_route_sel,        // Source pick per block input
    input wire logic [clb_pkg::NUM_TERMS-1:0][clb_pkg::LIT_W-1:0] cfg_lit,  // Literal use per term
    input wire logic [clb_pkg::NUM_CTL-1:0] cfg_ctl_inv,                    // Control term inversion
    input wire logic [clb_pkg::NUM_MC-1:0][clb_pkg::GRP_TERMS-1:0] cfg_sum, // Group terms per macrocell
    input wire logic [clb_pkg::NUM_MC-1:0][1:0] cfg_mode,                   // Storage mode per macrocell
    input wire logic [clb_pkg::NUM_MC-1:0][2:0] cfg_clk_sel,                // Clock pick per macrocell
    input wire logic cfg_clk_fall,                                          // Block clock polarity
    input wire logic [clb_pkg::NUM_MC-1:0] cfg_oe_sel,                      // Enable term pick in half
    input wire logic [clb_pkg::NUM_MC-1:0] cfg_out_inv,                     // Output inversion
    input wire logic [clb_pkg::NUM_MC-1:0] cfg_in_cap,                      // Buried input capture
    input wire logic cfg_low_power,                                         // Low power mode select
    output logic low_power                                                  // Mode now in force
);

    // Sizes the logic is written for; a mismatched source count would misplace the feedbacks
    if (EXT_W < 1 || SRC_W != 2 * clb_pkg::NUM_MC + clb_pkg::NUM_DED + EXT_W || SEL_W < $clog2(SRC_W)) begin : g_bad_cfg
        $error("clb_logic_block: unsupported source configuration");
    end

    typedef struct packed {
        logic [15:0] pin_s1;
        logic [15:0] pin_s2;
        logic [4:0] ded_s1;
        logic [4:0] ded_s2;
        logic [3:0] gclk_s1;
        logic [3:0] gclk_s2;
        logic [3:0] gclk_prev;
        logic pt_prev;
        logic [15:0] mc;
        logic [15:0] pin_out;
        logic [15:0] pin_oe;
        logic [15:0] hold;
        logic low_power;
    } clb_state_s;

    clb_state_s st_q;
    clb_state_s st_d;

    // Combinational view of the array, shared with the checks below
    logic [clb_pkg::NUM_IN-1:0] routed;
    logic [clb_pkg::LIT_W-1:0] lits;
    logic [clb_pkg::NUM_TERMS-1:0] terms;
    logic [clb_pkg::NUM_MC-1:0] sum;
    logic [clb_pkg::NUM_MC-1:0] edge_act;
    logic [clb_pkg::NUM_MC-1:0] level_act;
    logic [3:0] oe_t;
    logic set_act;
    logic rst_act;
    logic pt_clk;
    logic [SRC_W-1:0] src;

    // All sources of the routing matrix; pins enter only through their synchronisers
    assign src = {ext_src, st_q.mc, st_q.ded_s2, st_q.pin_s2};

    // Each block input picks one source; an out-of-range pick reads low
    always_comb begin
        for (int i = 0; i < clb_pkg::NUM_IN; i++) begin
            routed[i] = (int'(cfg_route_sel[i]) < SRC_W) ? src[cfg_route_sel[i]] : 1'b0;
        end
    end

    // True literals low, inverted literals high
    assign lits = {~routed, routed};

    // AND terms; a term with no literal chosen stays low so unused terms cannot fire
    generate
        for (genvar t = 0; t < clb_pkg::NUM_TERMS; t++) begin : g_term
            assign terms[t] = (|cfg_lit[t]) & (&(lits | ~cfg_lit[t]));
        end
    endgenerate

    // Control terms with their inversion, so one pass gives an AND or an OR
    assign oe_t = terms[clb_pkg::OE_BASE +: 4] ^ cfg_ctl_inv[3:0];
    assign set_act = terms[clb_pkg::SET_TERM] ^ cfg_ctl_inv[clb_pkg::INV_SET];
    assign rst_act = terms[clb_pkg::RST_TERM] ^ cfg_ctl_inv[clb_pkg::INV_RST];
    assign pt_clk = terms[clb_pkg::PTCLK_TERM] ^ cfg_ctl_inv[clb_pkg::INV_PTCLK];

    // Allocator: a macrocell ORs chosen terms of its group of four; beyond the sixteenth the
    // choices are dropped, which keeps any over-wide setting within the sum width
    always_comb begin
        int used;
        int base;
        used = 0;
        base = 0;
        for (int m = 0; m < clb_pkg::NUM_MC; m++) begin
            used = 0;
            sum[m] = 1'b0;
            base = (m / clb_pkg::GRP_MC) * clb_pkg::GRP_TERMS;
            for (int k = 0; k < clb_pkg::GRP_TERMS; k++) begin
                if (cfg_sum[m][k] && used < clb_pkg::MAX_SUM) begin
                    sum[m] = sum[m] | terms[base + k];
                    used = used + 1;
                end
            end
        end
    end

    // Clock pick and block-wide polarity; a global clock passes two sampling flops, so its edges act three cycles late
    always_comb begin
        logic cur;
        logic prev;
        cur = 1'b0;
        prev = 1'b0;
        for (int m = 0; m < clb_pkg::NUM_MC; m++) begin
            cur = 1'b0;
            prev = 1'b0;
            if (cfg_clk_sel[m] < clb_pkg::CLK_SEL_PT) begin
                cur = st_q.gclk_s2[cfg_clk_sel[m][1:0]];
                prev = st_q.gclk_prev[cfg_clk_sel[m][1:0]];
            end else if (cfg_clk_sel[m] == clb_pkg::CLK_SEL_PT) begin
                cur = pt_clk;
                prev = st_q.pt_prev;
            end
            level_act[m] = cur ^ cfg_clk_fall;
            edge_act[m] = (cur ^ cfg_clk_fall) & ~(prev ^ cfg_clk_fall);
        end
    end

    // Next state of the whole block
    always_comb begin
        logic d_in;
        logic [1:0] md;
        logic buried;
        d_in = 1'b0;
        md = 2'h0;
        buried = 1'b0;
        st_d = st_q;
        st_d.pin_s1 = pin_in;
        st_d.pin_s2 = st_q.pin_s1;
        st_d.ded_s1 = ded_in;
        st_d.ded_s2 = st_q.ded_s1;
        st_d.gclk_s1 = gclk_in;
        st_d.gclk_s2 = st_q.gclk_s1;
        st_d.gclk_prev = st_q.gclk_s2;
        st_d.pt_prev = pt_clk;
        st_d.low_power = cfg_low_power;
        for (int m = 0; m < clb_pkg::NUM_MC; m++) begin
            buried = ~IO_MASK[m];
            md = cfg_mode[m];
            d_in = sum[m];
            // Buried input capture takes the pin of the partner macrocell
            if (buried && cfg_in_cap[m]) begin
                d_in = st_q.pin_s2[m ^ 1];
                if (md != 2'(clb_pkg::CLB_MODE_LATCH))
                    md = 2'(clb_pkg::CLB_MODE_DREG);
            end
            if (md == 2'(clb_pkg::CLB_MODE_COMB)) begin
                st_d.mc[m] = d_in;
            end else if (rst_act) begin
                st_d.mc[m] = 1'b0;
            end else if (set_act) begin
                st_d.mc[m] = 1'b1;
            end else begin
                case (md)
                    2'(clb_pkg::CLB_MODE_DREG): begin
                        if (edge_act[m])
                            st_d.mc[m] = d_in;
                    end
                    2'(clb_pkg::CLB_MODE_TREG): begin
                        if (edge_act[m] && d_in)
                            st_d.mc[m] = ~st_q.mc[m];
                    end
                    2'(clb_pkg::CLB_MODE_LATCH): begin
                        if (level_act[m])
                            st_d.mc[m] = d_in;
                    end
                    default: begin
                        st_d.mc[m] = st_q.mc[m];
                    end
                endcase
            end
            // Pin side: inversion stage and enable from this half's pair of terms
            if (buried) begin
                st_d.pin_out[m] = 1'b0;
                st_d.pin_oe[m] = 1'b0;
            end else begin
                st_d.pin_out[m] = st_d.mc[m] ^ cfg_out_inv[m];
                if (m < clb_pkg::HALF_MC)
                    st_d.pin_oe[m] = cfg_oe_sel[m] ? oe_t[1] : oe_t[0];
                else
                    st_d.pin_oe[m] = cfg_oe_sel[m] ? oe_t[3] : oe_t[2];
            end
            // Hold keeps the last seen level while the driver is off
            if (st_q.pin_oe[m])
                st_d.hold[m] = st_q.pin_out[m];
            else
                st_d.hold[m] = st_q.pin_s2[m];
        end
    end

    // State register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
            st_q.mc <= clb_pkg::MC_RESET;
            st_q.gclk_prev <= clb_pkg::GCLK_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flip-flops; feedback leaves before the pin inversion
    assign fb_out = st_q.mc;
    assign pin_out = st_q.pin_out;
    assign pin_oe = st_q.pin_oe;
    assign pin_hold = st_q.hold;
    assign low_power = st_q.low_power;

    // Helper views for the checks
    logic [15:0] seq_mask;
    logic [15:0] t_flip;
    logic [15:0] d_load;
    always_comb begin
        for (int m = 0; m < clb_pkg::NUM_MC; m++) begin
            seq_mask[m] = (cfg_mode[m] != 2'(clb_pkg::CLB_MODE_COMB));
            t_flip[m] = (cfg_mode[m] == 2'(clb_pkg::CLB_MODE_TREG)) && !(~IO_MASK[m] && cfg_in_cap[m])
                && edge_act[m] && sum[m] && !set_act && !rst_act;
            d_load[m] = (cfg_mode[m] == 2'(clb_pkg::CLB_MODE_DREG)) && !cfg_in_cap[m]
                && edge_act[m] && !set_act && !rst_act;
        end
    end

    // Async terms act through the clock in this model, so their effect shows one cycle late
    property p_rst_wins;
        @(posedge clk) disable iff (reset) rst_act |=> ((st_q.mc & $past(seq_mask)) == 16'h0000);
    endproperty
    a_rst_wins: assert property (p_rst_wins) else $error("reset term did not clear registers");

    property p_set;
        @(posedge clk) disable iff (reset) (set_act && !rst_act) |=> ((st_q.mc & $past(seq_mask)) == $past(seq_mask));
    endproperty
    a_set: assert property (p_set) else $error("set term did not set registers");

    property p_toggle;
        @(posedge clk) disable iff (reset) (t_flip != 16'h0000) |=> ((st_q.mc & $past(t_flip)) == (~$past(st_q.mc) & $past(t_flip)));
    endproperty
    a_toggle: assert property (p_toggle) else $error("T register did not toggle");

    property p_dload;
        @(posedge clk) disable iff (reset) (d_load != 16'h0000) |=> ((st_q.mc & $past(d_load)) == ($past(sum) & $past(d_load)));
    endproperty
    a_dload: assert property (p_dload) else $error("D register did not load its sum");

    // Pin side: enable pick, inversion stage and buried quietness
    property p_oe_half;
        @(posedge clk) disable iff (reset) 1'b1 |=> (pin_oe[0] == (IO_MASK[0] && ($past(cfg_oe_sel[0]) ? $past(oe_t[1]) : $past(oe_t[0]))))
            && (pin_oe[8] == (IO_MASK[8] && ($past(cfg_oe_sel[8]) ? $past(oe_t[3]) : $past(oe_t[2]))));
    endproperty
    a_oe_half: assert property (p_oe_half) else $error("enable term picked from wrong half");

    property p_out_inv;
        @(posedge clk) disable iff (reset) 1'b1 |=> (pin_out == ((st_q.mc ^ $past(cfg_out_inv)) & IO_MASK));
    endproperty
    a_out_inv: assert property (p_out_inv) else $error("pin level does not match inverted result");

    property p_buried_quiet;
        @(posedge clk) disable iff (reset) ((pin_oe & ~IO_MASK) == 16'h0000);
    endproperty
    a_buried_quiet: assert property (p_buried_quiet) else $error("buried macrocell drives a pin");

    // Input paths: both pin kinds pass two flops before the array sees them
    property p_pin_sync;
        @(posedge clk) disable iff (reset) ##2 (st_q.pin_s2 == $past(pin_in, 2));
    endproperty
    a_pin_sync: assert property (p_pin_sync) else $error("pin path is not two stages");

    property p_ded_sync;
        @(posedge clk) disable iff (reset) ##2 (st_q.ded_s2 == $past(ded_in, 2));
    endproperty
    a_ded_sync: assert property (p_ded_sync) else $error("dedicated input path is not two stages");

    property p_latch_cap;
        @(posedge clk) disable iff (reset) (!IO_MASK[1] && cfg_in_cap[1] && cfg_mode[1] == 2'(clb_pkg::CLB_MODE_LATCH)
            && level_act[1] && !set_act && !rst_act) |=> (st_q.mc[1] == $past(st_q.pin_s2[0]));
    endproperty
    a_latch_cap: assert property (p_latch_cap) else $error("buried latch did not follow neighbour pin");

    property p_hold;
        @(posedge clk) disable iff (reset) 1'b1 |=> (pin_hold[0] == ($past(pin_oe[0]) ? $past(pin_out[0])
            : $past(st_q.pin_s2[0])));
    endproperty
    a_hold: assert property (p_hold) else $error("hold level lost while undriven");

    property p_low_power;
        @(posedge clk) disable iff (reset) ##1 (low_power == $past(cfg_low_power));
    endproperty
    a_low_power: assert property (p_low_power) else $error("power mode not taken");

    property p_sum_limit;
        @(posedge clk) disable iff (reset) ($countones(cfg_sum[0]) <= 16 && cfg_mode[0] == 2'(clb_pkg::CLB_MODE_COMB))
            |=> (st_q.mc[0] == $past(|(terms[19:0] & cfg_sum[0])));
    endproperty
    a_sum_limit: assert property (p_sum_limit) else $error("sum of steered terms wrong");

    c_toggle: cover property (@(posedge clk) disable iff (reset) t_flip != 16'h0000);
    c_both_async: cover property (@(posedge clk) disable iff (reset) set_act && rst_act);
    c_pin_driven: cover property (@(posedge clk) disable iff (reset) pin_oe != 16'h0000);
    c_pt_edge: cover property (@(posedge clk) disable iff (reset) pt_clk && !st_q.pt_prev);
    c_latch_cap: cover property (@(posedge clk) disable iff (reset) cfg_in_cap[1] && level_act[1]);

endmodule // clb_logic_block

// [bench/clb_pin_model.sv]
// Pad-side partner: resolves each pad from the block driver, an outside driver and the weak hold
`timescale 1ns/1ps

module clb_pin_model (
    input wire logic [clb_pkg::NUM_MC-1:0] pin_out, // Level the block drives
    input wire logic [clb_pkg::NUM_MC-1:0] pin_oe, // Block drives the pad
    input wire logic [clb_pkg::NUM_MC-1:0] pin_hold, // Weak hold level from the block
    input wire logic [clb_pkg::NUM_MC-1:0] ext_en, // Outside driver active
    input wire logic [clb_pkg::NUM_MC-1:0] ext_val, // Outside driver level
    output logic [clb_pkg::NUM_MC-1:0] pad // Resolved pad level
);
    // Block driver wins over the outside one; a pad nobody drives falls back to the weak
    // hold, which loses to any real driver, so it only matters while the pad floats
    always_comb begin
        for (int i = 0; i < clb_pkg::NUM_MC; i++) begin
            if (pin_oe[i]) begin
                pad[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pad[i] = ext_val[i];
            end else begin
                pad[i] = pin_hold[i];
            end
        end
    end
endmodule // clb_pin_model

// [bench/clb_logic_block_tb_top.sv]
// Self-checking bench for one logic block and its pads
`timescale 1ns/1ps

module clb_logic_block_tb_top;
    localparam logic [15:0] IO = 16'h5555; // Even macrocells own a pad
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] pin_in, pin_out, pin_oe, pin_hold, fb_out, ext_src, ext_en, ext_val;
    logic [15:0] cfg_oe_sel, cfg_out_inv, cfg_in_cap;
    logic [4:0] ded_in;
    logic [3:0] gclk_in, c;
    logic [35:0][5:0] cfg_route_sel;
    logic [86:0][71:0] cfg_lit;
    logic [6:0] cfg_ctl_inv;
    logic [15:0][19:0] cfg_sum;
    logic [15:0][1:0] cfg_mode;
    logic [15:0][2:0] cfg_clk_sel;
    logic cfg_clk_fall, cfg_low_power, low_power, q4, q5, v;
    logic [31:0] seed = 32'h00000009;
    logic [31:0] r;
    int n_mismatch = 0;
    int n_checks = 0;

    clb_logic_block #(.EXT_W(16), .IO_MASK(IO)) u_dut (
        .clk(clk), .reset(reset), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_hold(pin_hold),
        .ded_in(ded_in), .gclk_in(gclk_in), .ext_src(ext_src), .fb_out(fb_out), .cfg_route_sel(cfg_route_sel),
        .cfg_lit(cfg_lit), .cfg_ctl_inv(cfg_ctl_inv), .cfg_sum(cfg_sum), .cfg_mode(cfg_mode),
        .cfg_clk_sel(cfg_clk_sel), .cfg_clk_fall(cfg_clk_fall), .cfg_oe_sel(cfg_oe_sel),
        .cfg_out_inv(cfg_out_inv), .cfg_in_cap(cfg_in_cap), .cfg_low_power(cfg_low_power), .low_power(low_power));

    clb_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .pin_hold(pin_hold), .ext_en(ext_en),
        .ext_val(ext_val), .pad(pin_in));

    // Clock, 4 ns period
    initial begin
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Sums of mc3..mc0; mc3 selects all twenty terms but only the first sixteen count
    function automatic logic [3:0] exp_comb(input logic [15:0] x);
        logic t0, t1;
        t0 = x[0] & x[1];
        t1 = ~x[2];
        return {t0 | t1, 1'b0, t0, t0 | t1};
    endfunction

    // Upper half picks enable 0 or 1, lower half 2 or 3; buried macrocells never drive
    function automatic logic [15:0] exp_oe(input logic [3:0] inv, input logic [15:0] sel);
        logic [15:0] o;
        for (int m = 0; m < 16; m++) begin
            o[m] = IO[m] & inv[(m >= 8 ? 2 : 0) + int'(sel[m])];
        end
        return o;
    endfunction

    // Inputs always move the same 1 ns after an edge, well clear of sampling
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One edge of global clock 0; synchroniser plus compare needs three edges, four are given
    task automatic gstep(input logic lvl);
        ext_src = 16'(rnd());
        gclk_in[0] = lvl;
        tick(4);
        if (lvl !== cfg_clk_fall) begin
            q4 = ext_src[4];
            q5 = q5 ^ ext_src[5];
        end
        chk({13'h0000, fb_out[6:4]}, {13'h0000, 1'b0, q5, q4});
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Main sequence: configure, reset, then the scenarios
    initial begin
        {ext_src, ext_en, ext_val, cfg_oe_sel, cfg_in_cap} = '0;
        {gclk_in, ded_in, cfg_clk_fall, cfg_low_power, cfg_ctl_inv} = '0;
        {cfg_lit, cfg_sum, cfg_mode, cfg_clk_sel} = '0;
        cfg_out_inv = 16'h0001;
        for (int i = 0; i < 36; i++) begin
            cfg_route_sel[i] = (i < 16) ? 6'(37 + i) : 6'h00; // Inputs 16 and up see pad 0
        end
        cfg_lit[0][1:0] = 2'h3;
        cfg_lit[1][38] = 1'b1; // Inverted copy of input 2
        cfg_lit[19][3] = 1'b1;
        cfg_lit[20][4] = 1'b1;
        cfg_lit[21][5] = 1'b1;
        cfg_lit[22][16] = 1'b1;
        cfg_sum[0] = 20'h00003;
        cfg_sum[1] = 20'h00001; // Shares term 0 with mc0
        cfg_sum[3] = 20'hfffff;
        cfg_sum[4] = 20'h00001;
        cfg_sum[5] = 20'h00002;
        cfg_sum[6] = 20'h00001;
        cfg_sum[7] = 20'h00004;
        cfg_mode[4] = clb_pkg::CLB_MODE_DREG;
        cfg_mode[5] = clb_pkg::CLB_MODE_TREG;
        cfg_mode[6] = clb_pkg::CLB_MODE_DREG;
        cfg_clk_sel[6] = 3'h1; // Clock 1 stays quiet, so mc6 must hold
        repeat (4) @(posedge clk);
        chk(fb_out | pin_out | pin_oe, 16'h0000);
        #1 reset = 1'b0;
        // Combinational sums on all input corners, then random traffic
        for (int k = 0; k < 40; k++) begin
            ext_src = (k < 8) ? 16'(k) : 16'(rnd());
            tick(1);
            c = exp_comb(ext_src);
            chk({8'h00, pin_out[3:0], fb_out[3:0]}, {8'h00, 3'h0, ~c[0], c});
        end
        // Registers on rising, then falling edges; polarity swapped with data that cannot move them
        q4 = 1'b0;
        q5 = 1'b0;
        for (int k = 0; k < 24; k++) begin
            if (k == 12) begin
                ext_src = {11'h000, q4, 4'h0};
                cfg_clk_fall = 1'b1;
                tick(4);
            end
            gstep(1'b1);
            gstep(1'b0);
        end
        // Set, set with reset, reset alone; an active edge must not get through any of them
        for (int k = 0; k < 3; k++) begin
            cfg_ctl_inv = (k == 0) ? 7'h10 : (k == 1) ? 7'h30 : 7'h20;
            ext_src = (k == 0) ? 16'h0000 : 16'hffff;
            tick(2);
            chk({10'h000, fb_out[5:0]}, {10'h000, (k == 0) ? 2'h3 : 2'h0, exp_comb(ext_src)});
            gclk_in[0] = 1'b1;
            tick(4);
            gclk_in[0] = 1'b0;
            tick(4);
            chk({14'h0000, fb_out[5:4]}, {14'h0000, (k == 0) ? 2'h3 : 2'h0});
        end
        // Enable-term choice per half under random inversions
        for (int k = 0; k < 16; k++) begin
            r = rnd();
            cfg_ctl_inv = {3'h0, (k < 4) ? 4'(1 << k) : r[3:0]};
            cfg_oe_sel = (k < 4) ? {16{k[0]}} : r[31:16];
            tick(2);
            chk(pin_oe, exp_oe(cfg_ctl_inv[3:0], cfg_oe_sel));
        end
        cfg_ctl_inv = 7'h00;
        // Buried mc1 captures pad 0 through a low-level latch; pad 0 also routes to mc7
        cfg_mode[1] = clb_pkg::CLB_MODE_LATCH;
        cfg_in_cap[1] = 1'b1;
        cfg_clk_sel[1] = 3'h1;
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            v = r[3];
            ext_val = {15'h0000, v};
            ext_en = 16'h0001;
            tick(5);
            chk({14'h0000, fb_out[7], fb_out[1]}, {14'h0000, v, v});
            ext_en = 16'h0000;
            ext_val = {15'h0000, ~v};
            tick(5);
            chk({14'h0000, pin_hold[0], fb_out[7]}, {14'h0000, v, v});
        end
        gclk_in[1] = 1'b1; // Closes the latch under falling polarity
        tick(4);
        ext_val = {15'h0000, ~v};
        ext_en = 16'h0001;
        tick(5);
        chk({14'h0000, fb_out[7], fb_out[1]}, {14'h0000, ~v, v});
        // Speed or power mode, one cycle behind its setting
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            cfg_low_power = r[0];
            tick(1);
            chk({15'h0000, low_power}, {15'h0000, r[0]});
        end
        // Term clock on mc4 under falling polarity: a falling term loads, a steady low term holds
        cfg_clk_sel[4] = 3'h4;
        cfg_lit[86][8] = 1'b1;
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            ext_src = 16'h0100;
            tick(2);
            ext_src = {11'h000, r[0], 4'h0};
            tick(2);
            ext_src = {11'h000, ~r[0], 4'h0};
            tick(2);
            chk({15'h0000, fb_out[4]}, {15'h0000, r[0]});
        end
        // Dedicated inputs routed into mc2, visible three edges after they move
        cfg_lit[2][17] = 1'b1;
        cfg_sum[2] = 20'h00004;
        for (int k = 0; k < 10; k++) begin
            r = rnd();
            ded_in = r[4:0];
            cfg_route_sel[17] = 6'(16 + k % 5);
            tick(3);
            chk({15'h0000, fb_out[2]}, {15'h0000, r[k % 5]});
        end
        close_out();
    end

    // Watchdog: the scenarios need well under 1000 cycles
    initial begin
        #(4 * 5000);
        n_mismatch++;
        close_out();
    end
endmodule // clb_logic_block_tb_top
